// *** core/iot_pkg.sv ***
// Package for the internal oscillator trim register block: register
// indices, field layout, reset values, bus carriers and state types.
// Assumes a 32-bit AXI4-Lite register bus with 10-bit byte addresses.
`default_nettype none

package iot_pkg;

  // Bus geometry
  localparam int unsigned IOT_ADDR_W = 10;
  localparam int unsigned IOT_DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IOT_TRIM_IDX = 8'h18;
  localparam logic [7:0] IOT_CLOCK_CONFIG_LOCK_IDX = 8'h1b;
  localparam logic [7:0] IOT_CTRL_IDX = 8'h20;

  // Trim register field positions
  localparam int unsigned IOT_TC_MSB     = 15;
  localparam int unsigned IOT_TC_LSB     = 11;
  localparam int unsigned IOT_RSVD_BIT   = 10;
  localparam int unsigned IOT_FT_MSB     = 9;
  localparam int unsigned IOT_FT_LSB     = 0;
  localparam int unsigned IOT_COARSE_LSB = 6;

  // Protection and control register bit positions
  localparam int unsigned IOT_CLOCK_CONFIG_LOCK_BIT  = 0;
  localparam int unsigned IOT_PSEL_BIT  = 0;
  localparam int unsigned IOT_LOCKF_BIT = 1;
  localparam int unsigned IOT_OSCF_BIT  = 2;

  // Unlock key for the protection register
  localparam logic [7:0] IOT_UNLOCK_KEY = 8'h26;

  // Reset values
  localparam logic [15:0] IOT_TRIM_RST = 16'h0000;
  localparam logic        IOT_LOCK_RST = 1'b0;
  localparam logic        IOT_PSEL_RST = 1'b0;
  localparam logic        IOT_FLAG_RST = 1'b0;

  // AXI response codes
  localparam logic [1:0] IOT_RESP_OKAY   = 2'b00;
  localparam logic [1:0] IOT_RESP_SLVERR = 2'b10;

  // Master to slave signals of the register bus
  typedef struct packed {
    logic [IOT_ADDR_W-1:0] awaddr;
    logic                  awvalid;
    logic [IOT_DATA_W-1:0] wdata;
    logic [3:0]            wstrb;
    logic                  wvalid;
    logic                  bready;
    logic [IOT_ADDR_W-1:0] araddr;
    logic                  arvalid;
    logic                  rready;
  } iot_axi_req_t;

  // Slave to master signals of the register bus
  typedef struct packed {
    logic                  awready;
    logic                  wready;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [IOT_DATA_W-1:0] rdata;
    logic [1:0]            rresp;
  } iot_axi_rsp_t;

  // Decoded oscillator controls
  typedef struct packed {
    logic [3:0] coarse;
    logic [5:0] fine;
    logic       tc_comp_en;
    logic       tc_positive;
    logic [3:0] tc_magnitude;
  } iot_osc_ctl_t;

  // Register selected by an address
  typedef enum logic [1:0] {
    IOT_SEL_NONE = 2'b00,
    IOT_SEL_TRIM = 2'b01,
    IOT_SEL_CLOCK_CONFIG_LOCK = 2'b10,
    IOT_SEL_CTRL = 2'b11
  } iot_sel_t;

  // Phase of the block after reset
  typedef enum logic {
    IOT_PH_LOAD = 1'b0,
    IOT_PH_RUN  = 1'b1
  } iot_phase_t;

  // Whole state of the main module
  typedef struct packed {
    iot_phase_t            phase;
    logic                  aw_full;
    logic [IOT_ADDR_W-1:0] aw_addr;
    logic                  w_full;
    logic [IOT_DATA_W-1:0] w_data;
    logic [3:0]            w_strb;
    logic                  b_valid;
    logic [1:0]            b_resp;
    logic                  r_valid;
    logic [IOT_DATA_W-1:0] r_data;
    logic [1:0]            r_resp;
    logic [15:0]           trim;
    logic                  cfg_lock;
    logic                  pll_sel;
    logic                  lock_flag;
    logic                  osc_flag;
  } iot_state_t;

endpackage : iot_pkg

`default_nettype wire

// *** core/iot_trim_decode.sv ***
// Splits the held trim word into the controls the oscillator uses.
// Assumes the trim word comes from flip-flops in the parent module.
`default_nettype none

module iot_trim_decode (
  // Held trim word
  input  wire logic [15:0]          trim_word,
  // Decoded controls
  output iot_pkg::iot_osc_ctl_t     osc_ctl
);
  import iot_pkg::*;

  logic [4:0] tc_code;  // Temperature-coefficient code

  // Pure wiring and compare; no state here
  always_comb begin
    tc_code = trim_word[IOT_TC_MSB:IOT_TC_LSB];
    // Top four frequency bits make big steps, low six bits small ones
    osc_ctl.coarse = trim_word[IOT_FT_MSB:IOT_COARSE_LSB];
    osc_ctl.fine   = trim_word[IOT_COARSE_LSB-1:IOT_FT_LSB];
    // Sign bit picks direction, low bits the size of the shift
    osc_ctl.tc_positive  = tc_code[4];
    osc_ctl.tc_magnitude = tc_code[3:0];
    // Zero magnitude in either sign switches compensation off
    osc_ctl.tc_comp_en = (tc_code[3:0] != 4'h0);
  end

endmodule : iot_trim_decode

`default_nettype wire

// *** core/iot_trim_regs.sv ***
// Internal reference oscillator trim register block with its
// protection register and a small clock control/status register.
// Assumes an AXI4-Lite master on aclk and a factory value source
// that presents its word with a valid level after reset.
// Status pulses from the clock unit are synchronous to aclk.
//
// Function
// - Load factory trim when reset is released
// - Read always; trim and PLL select write only while unprotected
// - Trim write with PLL select clears flags
// - Temperature trim held at bits 15:11
// - Frequency trim held at bits 9:0
// - Upper four frequency bits give coarse steps
// - Lower six frequency bits give fine steps
// - Temperature codes 00000, 10000 disable compensation
// - Temperature trim is sign and magnitude
// - Key 0x26 unlocks; other writes lock
`default_nettype none

module iot_trim_regs (
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // Register bus
  input  wire iot_pkg::iot_axi_req_t s_axi_req,
  output iot_pkg::iot_axi_rsp_t     s_axi_rsp,
  // Factory value source
  input  wire logic [15:0]          nvm_trim_data,
  input  wire logic                 nvm_trim_valid,
  // Status events from the clock unit
  input  wire logic                 pll_lock_set,
  input  wire logic                 osc_up_set,
  // Oscillator controls
  output logic [4:0]                temp_coeff_trim,
  output logic [9:0]                ref_osc_freq_trim,
  output iot_pkg::iot_osc_ctl_t     osc_ctl,
  // Clock unit state
  output logic                      clock_config_lock,
  output logic                      pll_clock_select,
  output logic                      pll_lock_flag,
  output logic                      osc_up_flag,
  output logic                      trim_loaded
);
  import iot_pkg::*;

  // Register map, as word indices on the bus:
  //   trim word    - temperature code, spare bit, frequency trim
  //   protection   - bit 0 is the configuration lock, 1 = locked
  //   clock select - bit 0 PLL select, bit 1 PLL lock, bit 2 osc up
  // The two status flags are set only by the clock unit's pulses;
  // software clears them only as a side effect of a trim write.
  // A write is performed one edge after both halves are held, so a
  // read issued alongside sees the old value; software that needs
  // the new one reads after the write response.

  // Map a byte address onto one of the registers
  function automatic iot_sel_t addr_sel(
    input logic [IOT_ADDR_W-1:0] addr
  );
    iot_sel_t sel;
    // Anything not matched below stays unmapped
    sel = IOT_SEL_NONE;
    // Only aligned words are mapped
    if (addr[1:0] == 2'b00) begin
      unique case (addr[IOT_ADDR_W-1:2])
        IOT_TRIM_IDX: sel = IOT_SEL_TRIM;
        IOT_CLOCK_CONFIG_LOCK_IDX: sel = IOT_SEL_CLOCK_CONFIG_LOCK;
        IOT_CTRL_IDX: sel = IOT_SEL_CTRL;
        default:      sel = IOT_SEL_NONE;
      endcase
    end
    return sel;
  endfunction : addr_sel

  // Merge a write into the trim word under byte strobes
  function automatic logic [15:0] trim_merge(
    input logic [15:0] old_val,
    input logic [31:0] data,
    input logic [3:0]  strb
  );
    logic [15:0] v;
    // Start from the held word so unstrobed lanes keep it
    v = old_val;
    // Low lane: fine trim and the two lowest coarse bits
    if (strb[0]) begin
      v[7:0] = data[7:0];
    end
    // High lane: temperature code, spare bit, two coarse bits
    if (strb[1]) begin
      v[15:8] = data[15:8];
    end
    // Undefined bit never stores a one
    v[IOT_RSVD_BIT] = 1'b0;
    return v;
  endfunction : trim_merge

  // All state lives in one struct; the comb block fills the copy
  iot_state_t st_reg;   // Registered state
  iot_state_t st_next;  // Next state

  // Decode results shared by both comb blocks
  iot_sel_t   wr_sel;   // Register picked by the held write
  iot_sel_t   rd_sel;   // Register picked by the read address
  logic       wr_go;    // Held address and data perform now
  logic       ar_go;    // Read address taken now
  logic       trim_wr;  // Write reaches the trim register
  logic [31:0] rd_word; // Value for the read being taken

  // Ready terms are combinational from the held state
  // Both halves stall while a response waits: one write at a time
  assign s_axi_rsp.awready = !st_reg.aw_full && !st_reg.b_valid;
  assign s_axi_rsp.wready  = !st_reg.w_full && !st_reg.b_valid;
  assign s_axi_rsp.arready = !st_reg.r_valid;
  // Answers come straight from flip-flops
  assign s_axi_rsp.bvalid  = st_reg.b_valid;
  assign s_axi_rsp.bresp   = st_reg.b_resp;
  assign s_axi_rsp.rvalid  = st_reg.r_valid;
  assign s_axi_rsp.rdata   = st_reg.r_data;
  assign s_axi_rsp.rresp   = st_reg.r_resp;

  // Oscillator fields straight off the held word
  // Bit 10 drives nothing; it is only kept at zero
  assign temp_coeff_trim   = st_reg.trim[IOT_TC_MSB:IOT_TC_LSB];
  assign ref_osc_freq_trim = st_reg.trim[IOT_FT_MSB:IOT_FT_LSB];

  // Clock unit state
  // Lock reads back as 1 while the settings are protected
  assign clock_config_lock = st_reg.cfg_lock;
  assign pll_clock_select  = st_reg.pll_sel;
  assign pll_lock_flag     = st_reg.lock_flag;
  assign osc_up_flag       = st_reg.osc_flag;
  assign trim_loaded       = (st_reg.phase == IOT_PH_RUN);

  // Coarse/fine split and compensation sign decoding
  // Kept apart so the analogue side sees one decoded bundle
  iot_trim_decode u_decode (
    .trim_word (st_reg.trim),
    .osc_ctl   (osc_ctl)
  );

  // Decode and read mux
  always_comb begin
    // Handshake terms for this cycle
    wr_sel = addr_sel(st_reg.aw_addr);
    rd_sel = addr_sel(s_axi_req.araddr);
    wr_go  = st_reg.aw_full && st_reg.w_full && !st_reg.b_valid;
    ar_go  = s_axi_req.arvalid && !st_reg.r_valid;
    trim_wr = wr_go && (wr_sel == IOT_SEL_TRIM);
    // Bits above the defined ones read zero
    rd_word = '0;
    unique case (rd_sel)
      // Trim is readable whatever the lock says
      IOT_SEL_TRIM: rd_word[15:0] = st_reg.trim;
      IOT_SEL_CLOCK_CONFIG_LOCK: rd_word[IOT_CLOCK_CONFIG_LOCK_BIT] = st_reg.cfg_lock;
      IOT_SEL_CTRL: begin
        // Clock select plus the two sticky flags
        rd_word[IOT_PSEL_BIT]  = st_reg.pll_sel;
        rd_word[IOT_LOCKF_BIT] = st_reg.lock_flag;
        rd_word[IOT_OSCF_BIT]  = st_reg.osc_flag;
      end
      // Unmapped words read zero
      IOT_SEL_NONE: rd_word = '0;
    endcase
  end

  // Next-state logic for the whole block
  always_comb begin
    st_next = st_reg;
    // Default: every field holds its value

    // Factory load: hold the word at reset value until the source
    // reports valid, then take it once and never again until reset
    unique case (st_reg.phase)
      IOT_PH_LOAD: begin
        // Until the source is valid the trim keeps its reset value
        if (nvm_trim_valid) begin
          st_next.trim = nvm_trim_data;
          // Spare bit forced low even in the factory word
          st_next.trim[IOT_RSVD_BIT] = 1'b0;
          st_next.phase = IOT_PH_RUN;
        end
      end
      IOT_PH_RUN: begin
        // Run phase is final until the next reset
        st_next.phase = IOT_PH_RUN;
      end
    endcase

    // Catch write address and data separately, in either order
    // Address half
    if (s_axi_req.awvalid && s_axi_rsp.awready) begin
      st_next.aw_full = 1'b1;
      st_next.aw_addr = s_axi_req.awaddr;
    end
    // Data half
    if (s_axi_req.wvalid && s_axi_rsp.wready) begin
      st_next.w_full = 1'b1;
      st_next.w_data = s_axi_req.wdata;
      st_next.w_strb = s_axi_req.wstrb;
    end

    // Perform the write once both halves are held
    if (wr_go) begin
      // Both halves are consumed and the response is raised
      st_next.aw_full = 1'b0;
      st_next.w_full  = 1'b0;
      st_next.b_valid = 1'b1;
      st_next.b_resp  = IOT_RESP_OKAY;
      unique case (wr_sel)
        IOT_SEL_TRIM: begin
          // Byte strobes pick which half of the word changes
          // Locked writes and writes racing the factory load are
          // dropped silently; the bus still sees OKAY
          if (!st_reg.cfg_lock && st_reg.phase == IOT_PH_RUN) begin
            st_next.trim = trim_merge(st_reg.trim, st_reg.w_data,
                                      st_reg.w_strb);
          end
        end
        IOT_SEL_CLOCK_CONFIG_LOCK: begin
          // Every write here moves the lock one way or the other
          // Only the key in the low byte unlocks
          if (st_reg.w_strb[0] &&
              st_reg.w_data[7:0] == IOT_UNLOCK_KEY) begin
            st_next.cfg_lock = 1'b0;
          end else begin
            st_next.cfg_lock = 1'b1;
          end
        end
        IOT_SEL_CTRL: begin
          // Clock select is itself a protected setting
          // Status flags are read-only; only bit 0 is written
          if (!st_reg.cfg_lock && st_reg.w_strb[0]) begin
            st_next.pll_sel = st_reg.w_data[IOT_PSEL_BIT];
          end
        end
        IOT_SEL_NONE: begin
          // Unmapped word: error answer, nothing changes
          st_next.b_resp = IOT_RESP_SLVERR;
        end
      endcase
    end

    // Write response leaves when the master takes it
    // The master may hold bready high ahead of the response
    if (st_reg.b_valid && s_axi_req.bready) begin
      st_next.b_valid = 1'b0;
    end

    // Read: sample the word when the address is taken
    if (ar_go) begin
      st_next.r_valid = 1'b1;
      st_next.r_data  = rd_word;
      // Unmapped words answer with an error and zero data
      if (rd_sel == IOT_SEL_NONE) begin
        st_next.r_resp = IOT_RESP_SLVERR;
      end else begin
        st_next.r_resp = IOT_RESP_OKAY;
      end
    end else if (st_reg.r_valid && s_axi_req.rready) begin
      // Read data leaves when the master takes it
      st_next.r_valid = 1'b0;
    end

    // Trim write under PLL clock clears both flags, locked or not,
    // since the oscillator may be disturbed by the attempt
    if (trim_wr && st_reg.pll_sel) begin
      st_next.lock_flag = 1'b0;
      st_next.osc_flag  = 1'b0;
    end
    // A set arriving with the clear wins, so no event is lost
    // The pulses come from the clock unit only; software never
    // sets a flag
    if (pll_lock_set) begin
      st_next.lock_flag = 1'b1;
    end
    if (osc_up_set) begin
      st_next.osc_flag = 1'b1;
    end
  end

  // State register; reset gives constants, load happens afterwards
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Whole struct first, named reset values on top
      st_reg           <= '0;
      st_reg.phase     <= IOT_PH_LOAD;
      st_reg.trim      <= IOT_TRIM_RST;
      st_reg.cfg_lock  <= IOT_LOCK_RST;
      st_reg.pll_sel   <= IOT_PSEL_RST;
      st_reg.lock_flag <= IOT_FLAG_RST;
      st_reg.osc_flag  <= IOT_FLAG_RST;
      st_reg.b_resp    <= IOT_RESP_OKAY;
      st_reg.r_resp    <= IOT_RESP_OKAY;
    end else begin
      // Normal run: take the next state
      st_reg <= st_next;
    end
  end

endmodule : iot_trim_regs

`default_nettype wire

// *** verification/iot_trim_checker.sv ***
// Checker for the oscillator trim block, bound to its top module.
// Sees only top-level ports; reset is synchronous and active low.
`default_nettype none

module iot_trim_checker (
  // Clock and reset
  input wire logic                  aclk,
  input wire logic                  aresetn,
  // Register bus
  input wire iot_pkg::iot_axi_req_t s_axi_req,
  input wire iot_pkg::iot_axi_rsp_t s_axi_rsp,
  // Sources
  input wire logic [15:0]           nvm_trim_data,
  input wire logic                  nvm_trim_valid,
  input wire logic                  pll_lock_set,
  input wire logic                  osc_up_set,
  // Outputs watched
  input wire logic [4:0]            temp_coeff_trim,
  input wire logic [9:0]            ref_osc_freq_trim,
  input wire iot_pkg::iot_osc_ctl_t osc_ctl,
  input wire logic                  clock_config_lock,
  input wire logic                  pll_lock_flag,
  input wire logic                  osc_up_flag,
  input wire logic                  trim_loaded
);
  import iot_pkg::*;

  // One clock domain, so clock and disable are given once
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Factory word reaches both fields on the loading edge
  property p_load;
    nvm_trim_valid && !trim_loaded |=> trim_loaded &&
      temp_coeff_trim == $past(nvm_trim_data[15:11]) &&
      ref_osc_freq_trim == $past(nvm_trim_data[9:0]);
  endproperty
  a_load: assert property (p_load)
    else $error("factory trim not taken");

  property p_coarse;
    osc_ctl.coarse == ref_osc_freq_trim[9:6];
  endproperty
  a_coarse: assert property (p_coarse)
    else $error("coarse step wrong");

  property p_fine;
    osc_ctl.fine == ref_osc_freq_trim[5:0];
  endproperty
  a_fine: assert property (p_fine)
    else $error("fine step wrong");

  // Both zero-magnitude codes switch compensation off
  property p_tc_off;
    osc_ctl.tc_comp_en == (temp_coeff_trim[3:0] != 4'h0);
  endproperty
  a_tc_off: assert property (p_tc_off)
    else $error("compensation enable wrong");

  property p_tc_sign;
    osc_ctl.tc_positive == temp_coeff_trim[4] &&
      osc_ctl.tc_magnitude == temp_coeff_trim[3:0];
  endproperty
  a_tc_sign: assert property (p_tc_sign)
    else $error("sign magnitude split wrong");

  // Locked trim never moves after the factory load
  property p_lock_hold;
    trim_loaded && clock_config_lock |=>
      $stable({temp_coeff_trim, ref_osc_freq_trim});
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("trim changed while locked");

  property p_rd_ans;
    s_axi_req.arvalid && s_axi_rsp.arready |=> s_axi_rsp.rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read not answered next cycle");

  property p_bit10;
    s_axi_rsp.rvalid |-> !s_axi_rsp.rdata[10];
  endproperty
  a_bit10: assert property (p_bit10)
    else $error("bit 10 read as one");

  // A lock set pulse always wins over a clearing write
  property p_lock_set;
    pll_lock_set |=> pll_lock_flag;
  endproperty
  a_lock_set: assert property (p_lock_set)
    else $error("lock flag not set");

  property p_up_quiet;
    !osc_up_set && !osc_up_flag |=> !osc_up_flag;
  endproperty
  a_up_quiet: assert property (p_up_quiet)
    else $error("oscillator flag rose alone");

endmodule : iot_trim_checker

bind iot_trim_regs iot_trim_checker i_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_req(s_axi_req),
  .s_axi_rsp(s_axi_rsp), .nvm_trim_data(nvm_trim_data),
  .nvm_trim_valid(nvm_trim_valid), .pll_lock_set(pll_lock_set),
  .osc_up_set(osc_up_set), .temp_coeff_trim(temp_coeff_trim),
  .ref_osc_freq_trim(ref_osc_freq_trim), .osc_ctl(osc_ctl),
  .clock_config_lock(clock_config_lock), .pll_lock_flag(pll_lock_flag),
  .osc_up_flag(osc_up_flag), .trim_loaded(trim_loaded));

`default_nettype wire

// *** verification/testbench.sv ***
// Testbench for the oscillator trim block: AXI4-Lite tasks, read queue.
// Assumes the package, the design and the checker compile first.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import iot_pkg::*;

  localparam logic [9:0] A_TRIM = {IOT_TRIM_IDX, 2'b00};
  localparam logic [9:0] A_CLOCK_CONFIG_LOCK = {IOT_CLOCK_CONFIG_LOCK_IDX, 2'b00};
  localparam logic [9:0] A_CTRL = {IOT_CTRL_IDX, 2'b00};

  logic         aclk, aresetn, nv_valid, lk_set, up_set;
  logic         lock, psel, lkf, upf, loaded;
  logic [15:0]  nv_data, exp_t, d;
  logic [4:0]   tc;
  logic [9:0]   ft;
  logic [7:0]   keys [4];
  iot_axi_req_t req;
  iot_axi_rsp_t rsp;
  iot_osc_ctl_t ctl;
  logic [33:0]  expq [$];   // Expected {rresp, rdata} per read
  logic [1:0]   bq [$];     // Expected bresp per write
  int           check_count, bad_count;

  iot_trim_regs i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_req(req),
    .s_axi_rsp(rsp), .nvm_trim_data(nv_data), .nvm_trim_valid(nv_valid),
    .pll_lock_set(lk_set), .osc_up_set(up_set), .temp_coeff_trim(tc),
    .ref_osc_freq_trim(ft), .osc_ctl(ctl), .clock_config_lock(lock),
    .pll_clock_select(psel), .pll_lock_flag(lkf), .osc_up_flag(upf),
    .trim_loaded(loaded));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic chk(input string n, input logic [33:0] e, g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run

  // Handshakes are sampled mid-cycle, where nothing is changing
  task automatic wr(input logic [9:0] a, input logic [31:0] dat,
                    input logic [3:0] s = 4'hf,
                    input logic [1:0] eb = IOT_RESP_OKAY);
    logic ta, tw, tb;
    bq.push_back(eb);
    @(posedge aclk);
    req.awaddr <= a;
    req.wdata <= dat;
    req.wstrb <= s;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    repeat (40) begin
      @(negedge aclk);
      ta = req.awvalid && rsp.awready;
      tw = req.wvalid && rsp.wready;
      tb = rsp.bvalid;
      @(posedge aclk);
      if (ta) req.awvalid <= 1'b0;
      if (tw) req.wvalid <= 1'b0;
      if (tb) break;
    end
    chk("write_done", 34'h1, 34'(tb));
    req.bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [33:0] e);
    logic ta, tr;
    expq.push_back(e);
    @(posedge aclk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    repeat (40) begin
      @(negedge aclk);
      ta = req.arvalid && rsp.arready;
      tr = rsp.rvalid;
      @(posedge aclk);
      if (ta) req.arvalid <= 1'b0;
      if (tr) break;
    end
    chk("read_done", 34'h1, 34'(tr));
    req.rready <= 1'b0;
  endtask : rd

  task automatic pulse();
    @(posedge aclk);
    lk_set <= 1'b1;
    up_set <= 1'b1;
    @(posedge aclk);
    lk_set <= 1'b0;
    up_set <= 1'b0;
  endtask : pulse

  // Each accepted read result is matched to the oldest note
  always @(negedge aclk) begin
    if (aresetn && rsp.rvalid && req.rready) begin
      if (expq.size() == 0) chk("read", '1, {rsp.rresp, rsp.rdata});
      else chk("read", expq.pop_front(), {rsp.rresp, rsp.rdata});
    end
    // Each accepted write response is matched the same way
    if (aresetn && rsp.bvalid && req.bready) begin
      if (bq.size() == 0) chk("bresp", '1, 34'(rsp.bresp));
      else chk("bresp", 34'(bq.pop_front()), 34'(rsp.bresp));
    end
  end

  // Whole run is a few hundred cycles, far below this 20000-cycle limit
  initial begin
    #100000;
    bad_count++;
    complete_run();
  end

  initial begin
    req = '0;
    aresetn = 1'b0;
    nv_valid = 1'b0;
    lk_set = 1'b0;
    up_set = 1'b0;
    check_count = 0;
    bad_count = 0;
    keys = '{8'h27, 8'h26, 8'h00, 8'h26};
    void'($urandom(61));
    nv_data = 16'($urandom());
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // Writes before the factory load are dropped
    wr(A_TRIM, 32'hffff);
    rd(A_TRIM, 34'h0);
    @(posedge aclk);
    nv_valid <= 1'b1;
    exp_t = nv_data & 16'hfbff;
    repeat (2) @(negedge aclk);
    chk("loaded", 34'h1, 34'(loaded));
    chk("tc", 34'(exp_t[15:11]), 34'(tc));
    chk("ft", 34'(exp_t[9:0]), 34'(ft));
    rd(A_TRIM, 34'(exp_t));
    repeat (6) begin
      exp_t = 16'($urandom());
      wr(A_TRIM, {16'h0, exp_t});
      exp_t[10] = 1'b0;
      rd(A_TRIM, 34'(exp_t));
    end
    // Every temperature code, both signs, each followed by a retune
    for (int i = 0; i < 32; i++) begin
      wr(A_TRIM, 32'(i) << 11);
      @(negedge aclk);
      chk("comp_en", 34'(i % 16 != 0), 34'(ctl.tc_comp_en));
      chk("sign", 34'(i / 16), 34'(ctl.tc_positive));
      wr(A_TRIM, (32'(i) << 11) | 32'h0155);
      @(negedge aclk);
      chk("retune", 34'h155, 34'(ft));
    end
    exp_t = 16'hf955;
    for (int k = 0; k < 4; k++) begin
      wr(A_CLOCK_CONFIG_LOCK, 32'(keys[k]));
      rd(A_CLOCK_CONFIG_LOCK, 34'(keys[k] != IOT_UNLOCK_KEY));
      d = 16'($urandom());
      wr(A_TRIM, {16'h0, d});
      if (keys[k] == IOT_UNLOCK_KEY) exp_t = d & 16'hfbff;
      rd(A_TRIM, 34'(exp_t));
    end
    // Byte lanes: only the strobed half of the trim word moves
    wr(A_TRIM, 32'ha5c3, 4'h1);
    exp_t[7:0] = 8'hc3;
    rd(A_TRIM, 34'(exp_t));
    wr(A_TRIM, 32'ha5c3, 4'h2);
    exp_t[15:8] = 8'ha1;
    rd(A_TRIM, 34'(exp_t));
    // The key without its low-byte strobe still locks
    wr(A_CLOCK_CONFIG_LOCK, 32'h26, 4'h2);
    rd(A_CLOCK_CONFIG_LOCK, 34'h1);
    wr(A_CLOCK_CONFIG_LOCK, 32'h26);
    // Flags clear only when the select bit is set
    pulse();
    rd(A_CTRL, 34'h6);
    @(negedge aclk);
    chk("flags", 34'h3, 34'({lkf, upf}));
    wr(A_TRIM, 32'h0);
    rd(A_CTRL, 34'h6);
    wr(A_CTRL, 32'h1);
    @(negedge aclk);
    chk("psel", 34'h1, 34'(psel));
    wr(A_TRIM, 32'h0);
    rd(A_CTRL, 34'h1);
    pulse();
    wr(A_CLOCK_CONFIG_LOCK, 32'h0);
    wr(A_TRIM, 32'hffff);
    wr(A_CTRL, 32'h0);
    rd(A_CTRL, 34'h1);
    @(negedge aclk);
    chk("flags", 34'h0, 34'({lkf, upf}));
    chk("lock", 34'h1, 34'(lock));
    rd(A_TRIM, 34'h0);
    wr(10'h3fc, 32'hffffffff, 4'hf, IOT_RESP_SLVERR);
    rd(10'h3fc, {IOT_RESP_SLVERR, 32'h0});
    chk("queue", 34'h0, 34'(expq.size()));
    chk("bqueue", 34'h0, 34'(bq.size()));
    complete_run();
  end

endmodule : testbench

`default_nettype wire
